// File: cfr_pkg.sv
package cfr_pkg;

  // Coprocessor-0 location of the feature word.
  localparam logic [4:0] CP0_REG_NUM = 5'h10;
  localparam logic [2:0] CP0_SEL_NUM = 3'h3;

  // Field positions inside the feature word.
  localparam int NEXT_WORD_BIT   = 31;
  localparam int EXC_ISA_BIT     = 16;
  localparam int ISA_AVAIL_LO    = 14;
  localparam int ISA_AVAIL_HI    = 15;

  // Hardwired field values.
  localparam logic       NEXT_WORD_VAL    = 1'b1;
  localparam logic [7:0] UNIMPL_HIGH_VAL  = 8'h00;
  localparam logic [1:0] PRIO_WIDTH_VAL   = 2'h1;
  localparam logic [2:0] COMP_REV_VAL     = 3'h0;
  localparam logic       MCU_EXT_VAL      = 1'b1;
  localparam logic       ISA_BOTH_VAL     = 1'b1;
  localparam logic       USER_LOCAL_VAL   = 1'b1;
  localparam logic       RD_EXEC_INH_VAL  = 1'b1;
  localparam logic       SIGPROC_REV2_VAL = 1'b1;
  localparam logic       SIGPROC_EXT_VAL  = 1'b1;
  localparam logic       UNIMPL_BIT9_VAL  = 1'b0;
  localparam logic       FLOW_TRACE_VAL   = 1'b1;
  localparam logic       UNIMPL_BIT7_VAL  = 1'b0;
  localparam logic       EXT_IRQ_VAL      = 1'b1;
  localparam logic       VEC_IRQ_VAL      = 1'b1;
  localparam logic       SMALL_PAGE_VAL   = 1'b0;
  localparam logic       DEV_MAP_VAL      = 1'b1;
  localparam logic [1:0] UNIMPL_LOW_VAL   = 2'h0;
  localparam logic       TRACE_LOGIC_VAL  = 1'b0;

  // Values held before the boot configuration has been taken.
  localparam logic       EXC_ISA_RESET    = 1'b0;
  localparam logic [1:0] ISA_AVAIL_RESET  = 2'h2;
  localparam logic [31:0] RD_DATA_RESET   = 32'h0000_0000;

  // Edges after reset release before the synchronised strap is valid.
  localparam logic [1:0] STRAP_SETTLE_CYCLES = 2'h3;

  // One coprocessor-0 access from the core pipeline.
  typedef struct packed {
    logic        rd_en;
    logic        wr_en;
    logic [4:0]  reg_num;
    logic [2:0]  sel;
    logic [31:0] wr_data;
  } cfr_cp0_req_s;

endpackage : cfr_pkg

// File: cfr_boot_strap.sv
`timescale 1ns/1ps

module cfr_boot_strap (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic reset,
  // Boot configuration strap
  input  wire logic boot_isa_select,
  // Captured value
  output logic      strap_value,
  output logic      strap_load
);

  typedef enum logic [2:0] {
    CFR_ST_SETTLE = 3'h1,
    CFR_ST_LOAD   = 3'h2,
    CFR_ST_RUN    = 3'h4
  } cfr_strap_state_e;

  cfr_strap_state_e state;
  logic             sync_first;
  logic             sync_second;
  logic [1:0]       settle_cnt;

  wire settle_done = (settle_cnt == cfr_pkg::STRAP_SETTLE_CYCLES - 2'h1);

  // Two-stage synchroniser for the strap level.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      sync_first  <= 1'b0;
      sync_second <= 1'b0;
    end else begin
      sync_first  <= boot_isa_select;
      sync_second <= sync_first;
    end
  end

  // Waits for the synchroniser to fill, then issues one load pulse.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      state       <= CFR_ST_SETTLE;
      settle_cnt  <= 2'h0;
      strap_value <= 1'b0;
      strap_load  <= 1'b0;
    end else begin
      strap_load <= 1'b0;
      unique case (state)
        CFR_ST_SETTLE: begin
          settle_cnt <= settle_cnt + 2'h1;
          if (settle_done) begin
            state <= CFR_ST_LOAD;
          end
        end
        CFR_ST_LOAD: begin
          strap_value <= sync_second;
          strap_load  <= 1'b1;
          state       <= CFR_ST_RUN;
        end
        CFR_ST_RUN: begin
          state <= CFR_ST_RUN;
        end
        default: begin
          state <= CFR_ST_SETTLE;
        end
      endcase
    end
  end

endmodule : cfr_boot_strap

// File: cfr_core_feature_word.sv
`timescale 1ns/1ps

module cfr_core_feature_word (
  // Clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 reset,
  // Boot configuration strap
  input  wire logic                 boot_isa_select,
  // Coprocessor-0 access
  input  wire cfr_pkg::cfr_cp0_req_s cp0_req,
  output logic [31:0]               cp0_rd_data,
  output logic                      cp0_rd_valid,
  // Core-facing state
  output logic                      exception_isa_select,
  output logic [1:0]                isa_availability,
  output logic                      boot_loaded
);

  logic        strap_value;
  logic        strap_load;
  logic [31:0] feature_word;

  // Address decode for coprocessor-0 register 16, select 3.
  wire addr_hit = (cp0_req.reg_num == cfr_pkg::CP0_REG_NUM) &&
                  (cp0_req.sel == cfr_pkg::CP0_SEL_NUM);
  wire rd_hit   = cp0_req.rd_en && addr_hit;
  wire wr_hit   = cp0_req.wr_en && addr_hit;

  // Strap capture after reset release.
  cfr_boot_strap u_strap (
    .core_clk        (core_clk),
    .reset           (reset),
    .boot_isa_select (boot_isa_select),
    .strap_value     (strap_value),
    .strap_load      (strap_load)
  );

  // Assembly of the read value from constants and live state.
  // Next word flag.
  assign feature_word = {
    cfr_pkg::NEXT_WORD_VAL,
    cfr_pkg::UNIMPL_HIGH_VAL,
    cfr_pkg::PRIO_WIDTH_VAL,
    cfr_pkg::COMP_REV_VAL,
    cfr_pkg::MCU_EXT_VAL,
    exception_isa_select,
    isa_availability,
    cfr_pkg::USER_LOCAL_VAL,
    cfr_pkg::RD_EXEC_INH_VAL,
    cfr_pkg::SIGPROC_REV2_VAL,
    cfr_pkg::SIGPROC_EXT_VAL,
    cfr_pkg::UNIMPL_BIT9_VAL,
    cfr_pkg::FLOW_TRACE_VAL,
    cfr_pkg::UNIMPL_BIT7_VAL,
    cfr_pkg::EXT_IRQ_VAL,
    cfr_pkg::VEC_IRQ_VAL,
    cfr_pkg::SMALL_PAGE_VAL,
    cfr_pkg::DEV_MAP_VAL,
    cfr_pkg::UNIMPL_LOW_VAL,
    cfr_pkg::TRACE_LOGIC_VAL
  };

  // Boot load takes priority over a software write in the same cycle.
  // Strap load.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      exception_isa_select <= cfr_pkg::EXC_ISA_RESET;
      isa_availability     <= cfr_pkg::ISA_AVAIL_RESET;
      boot_loaded          <= 1'b0;
    end else if (strap_load) begin
      exception_isa_select <= strap_value;
      isa_availability     <= {cfr_pkg::ISA_BOTH_VAL, strap_value};
      boot_loaded          <= 1'b1;
    end else if (wr_hit) begin
      exception_isa_select <= cp0_req.wr_data[cfr_pkg::EXC_ISA_BIT];
    end
  end

  // Registered read answer; other registers read as zero here.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      cp0_rd_data  <= cfr_pkg::RD_DATA_RESET;
      cp0_rd_valid <= 1'b0;
    end else begin
      cp0_rd_data  <= rd_hit ? feature_word : cfr_pkg::RD_DATA_RESET;
      cp0_rd_valid <= rd_hit;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  // Checks on every returned read value, on writes and boot loads, and on the live select and availability state.
  // Next word check.
  next_word_a: assert property (cp0_rd_valid |-> cp0_rd_data[31] == 1'b1)
    else $error("feature word bit 31 not one");

  upper_zero_a: assert property (cp0_rd_valid |-> cp0_rd_data[30:23] == 8'h00)
    else $error("feature word bits 30 to 23 not zero");

  prio_width_a: assert property (cp0_rd_valid |-> cp0_rd_data[22:21] == 2'h1)
    else $error("priority width field not 01");

  comp_rev_a: assert property (cp0_rd_valid |-> cp0_rd_data[20:18] == 3'h0)
    else $error("compressed revision field not 000");

  mcu_ext_a: assert property (cp0_rd_valid |-> cp0_rd_data[17] == 1'b1)
    else $error("extension bit 17 not one");

  exc_write_a: assert property (wr_hit && !strap_load |=>
      exception_isa_select == $past(cp0_req.wr_data[16]))
    else $error("exception select did not take written value");

  exc_read_a: assert property (rd_hit |=>
      cp0_rd_data[16] == $past(exception_isa_select))
    else $error("bit 16 read differs from select state");

  // Availability tracks the select loaded at boot.
  // The read shows the state of the cycle before, so the load flag is taken from then too.
  isa_field_a: assert property (cp0_rd_valid && $past(boot_loaded) |->
      cp0_rd_data[15] == 1'b1 && cp0_rd_data[14] == strap_value)
    else $error("availability field wrong for boot strap");

  // Strap load lands in both fields one cycle later.
  boot_load_a: assert property (strap_load |=>
      boot_loaded && exception_isa_select == $past(strap_value) &&
      isa_availability == {1'b1, $past(strap_value)})
    else $error("boot strap not loaded");

  avail_code_a: assert property (boot_loaded |->
      isa_availability == {1'b1, strap_value})
    else $error("availability code does not match boot strap");

  exc_hold_a: assert property (!strap_load && !wr_hit |=>
      $stable(exception_isa_select))
    else $error("exception select changed without a write");

  isa_hold_a: assert property (!strap_load |=>
      $stable(isa_availability))
    else $error("availability field changed without a boot load");

  opt_flags_a: assert property (cp0_rd_valid |-> cp0_rd_data[13:10] == 4'hF)
    else $error("bits 13 to 10 not all one");

  flow_trace_a: assert property (cp0_rd_valid |-> cp0_rd_data[8] == 1'b1)
    else $error("flow trace bit not one");

  irq_support_a: assert property (cp0_rd_valid |-> cp0_rd_data[6:5] == 2'h3)
    else $error("interrupt support bits not one");

  page_size_a: assert property (cp0_rd_valid |-> cp0_rd_data[4] == 1'b0)
    else $error("small page bit not zero");

  dev_map_a: assert property (cp0_rd_valid |-> cp0_rd_data[3] == 1'b1)
    else $error("device map bit not one");

  trace_logic_a: assert property (cp0_rd_valid |-> cp0_rd_data[0] == 1'b0)
    else $error("trace logic bit not zero");

  low_zero_a: assert property (cp0_rd_valid |->
      cp0_rd_data[9] == 1'b0 && cp0_rd_data[7] == 1'b0 && cp0_rd_data[2:1] == 2'h0)
    else $error("unimplemented low bits not zero");

  ro_stable_a: assert property (wr_hit && !strap_load |=>
      feature_word[31:17] == $past(feature_word[31:17]) &&
      feature_word[15:0] == $past(feature_word[15:0]))
    else $error("write changed a read-only field");

  // Main scenarios.
  boot_seen_c: cover property (strap_load ##1 boot_loaded);
  write_set_c: cover property (wr_hit && cp0_req.wr_data[16] ##1 exception_isa_select);
  read_back_c: cover property (wr_hit ##1 rd_hit ##1 cp0_rd_valid);
  compressed_c: cover property (cp0_rd_valid && cp0_rd_data[15:14] == 2'h3);
  refused_c: cover property (cp0_req.rd_en && !addr_hit);

endmodule : cfr_core_feature_word

// File: tb_top.sv
`timescale 1ns/1ps

module tb_top;

  // Clock, reset and strap.
  logic                  core_clk;
  logic                  reset;
  logic                  boot_isa_select;
  // Access request and observed outputs.
  cfr_pkg::cfr_cp0_req_s req;
  logic [31:0]           cp0_rd_data;
  logic                  cp0_rd_valid;
  logic                  exception_isa_select;
  logic [1:0]            isa_availability;
  logic                  boot_loaded;
  // Bench bookkeeping.
  int                    err_total;
  int                    comparisons;
  int                    cycles;
  logic [31:0]           rd_word;
  logic                  rd_vld;

  cfr_core_feature_word cfr_core_feature_word_inst (
    .core_clk             (core_clk),
    .reset                (reset),
    .boot_isa_select      (boot_isa_select),
    .cp0_req              (req),
    .cp0_rd_data          (cp0_rd_data),
    .cp0_rd_valid         (cp0_rd_valid),
    .exception_isa_select (exception_isa_select),
    .isa_availability     (isa_availability),
    .boot_loaded          (boot_loaded)
  );

  // The clock toggles every half period of 5 ns.
  always #5 core_clk = ~core_clk;

  // A hang is cut short after a cycle ceiling well beyond the test length.
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 1000) begin
      err_total++;
      end_sim();
    end
  end

  // Expected feature word for a given exception select and strap.
  function automatic logic [31:0] exp_word(input logic e, input logic s);
    return {1'h1, 8'h00, 2'h1, 3'h0, 1'h1, e, 1'h1, s, 4'hF, 1'h0, 1'h1, 8'h68};
  endfunction : exp_word

  // Compares one value and reports a difference at once.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : chk

  // One read access; the answer is sampled at the falling edge half a cycle after the taking edge.
  task automatic rd(input logic [4:0] r, input logic [2:0] s);
    @(posedge core_clk);
    req.rd_en   <= 1'b1;
    req.reg_num <= r;
    req.sel     <= s;
    @(posedge core_clk);
    req.rd_en <= 1'b0;
    @(negedge core_clk);
    rd_word = cp0_rd_data;
    rd_vld  = cp0_rd_valid;
  endtask : rd

  // One write access to the feature word.
  task automatic wr(input logic [31:0] d);
    @(posedge core_clk);
    req.wr_en   <= 1'b1;
    req.reg_num <= cfr_pkg::CP0_REG_NUM;
    req.sel     <= cfr_pkg::CP0_SEL_NUM;
    req.wr_data <= d;
    @(posedge core_clk);
    req.wr_en <= 1'b0;
    @(negedge core_clk);
  endtask : wr

  // Resets with a given strap, checks defaults, then waits for the boot load.
  task automatic do_reset(input logic s);
    @(posedge core_clk);
    reset           <= 1'b1;
    boot_isa_select <= s;
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    chk({31'h0, cp0_rd_valid}, 32'h0, "valid in reset");
    chk(cp0_rd_data, 32'h0, "data in reset");
    chk({31'h0, boot_loaded}, 32'h0, "loaded in reset");
    chk({30'h0, isa_availability}, 32'h2, "avail in reset");
    @(posedge core_clk);
    reset <= 1'b0;
    for (int n = 0; n < 10 && boot_loaded !== 1'b1; n++) begin
      @(negedge core_clk);
    end
    chk({31'h0, boot_loaded}, 32'h1, "boot load done");
  endtask : do_reset

  // Prints the counts and the verdict, then stops.
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_sim

  // Main sequence: one boot per strap value, then refused accesses.
  initial begin
    core_clk        = 1'b0;
    reset           = 1'b1;
    boot_isa_select = 1'b0;
    req             = '0;
    err_total       = 0;
    comparisons     = 0;
    cycles          = 0;
    for (int s = 1; s >= 0; s--) begin
      do_reset(s[0]);
      // The strap value is loaded at boot.
      chk({31'h0, exception_isa_select}, {31'h0, s[0]}, "exc select boot");
      chk({30'h0, isa_availability}, {30'h0, 1'b1, s[0]}, "avail boot");
      rd(cfr_pkg::CP0_REG_NUM, cfr_pkg::CP0_SEL_NUM);
      chk({31'h0, rd_vld}, 32'h1, "read valid");
      chk(rd_word, exp_word(s[0], s[0]), "word after boot");
      chk(rd_word, exp_word(s[0], s[0]), "fixed fields");
      chk(rd_word & 32'h0000_0287, 32'h0000_0000, "zero bits");
      @(negedge core_clk);
      chk({31'h0, cp0_rd_valid}, 32'h0, "valid one cycle");
      chk(cp0_rd_data, 32'h0, "data one cycle");
      // A write flips the select; other bits are ignored.
      wr(s[0] ? 32'h0000_0000 : 32'hFFFF_FFFF);
      chk({31'h0, exception_isa_select}, {31'h0, ~s[0]}, "exc select write");
      rd(cfr_pkg::CP0_REG_NUM, cfr_pkg::CP0_SEL_NUM);
      chk(rd_word, exp_word(~s[0], s[0]), "word after write");
      chk({30'h0, isa_availability}, {30'h0, 1'b1, s[0]}, "avail after write");
    end
    // Accesses to other locations give neither valid nor data.
    rd(cfr_pkg::CP0_REG_NUM, 3'h2);
    chk({rd_vld, rd_word[30:0]} | rd_word, 32'h0, "other select");
    rd(5'h0F, cfr_pkg::CP0_SEL_NUM);
    chk({rd_vld, rd_word[30:0]} | rd_word, 32'h0, "other register");
    end_sim();
  end

endmodule : tb_top
